// [pkg/rgt_regs.svh]
// rgt_regs.svh: register indexes, field positions, reset values and codes
// of the regulator-two control register set.
// assumes an AXI4-Lite host, 32-bit data, byte address = four times index.
//
// Contract
// - bit 14 set: switch mode, code ignored
// - bit 10 clear: discharge output while disabled
// - all four regulators off: always discharge
// - code maps 0.9V/50mV then 1.8V/100mV
// - state machine restores all fields' defaults; code restores control, timing, low-power only
// - fault action: ignore, regulator off, system off
// - every fault raises interrupt, whatever the action; code always latches status, irq only when the mask bit is set
// - start slot: off, slots 1-14, active
// - stop slot: slots 1-14, else on off
// - sleep behaviour: image settings or output off
// - sleep source: register bit or inputs 1-3
// - sleep voltage code, same map, reset 11100
// - register group repeats every three indexes
`ifndef RGT_REGS_SVH
`define RGT_REGS_SVH
`define RGT_ADDR_W 10
`define RGT_IDX_W 8
`define RGT_IDX_CTRL 8'hCB
`define RGT_IDX_TIME 8'hCC
`define RGT_IDX_LP 8'hCD
`define RGT_IDX_STAT 8'hD8
`define RGT_IDX_MASK 8'hD9
`define RGT_IDX_HIB 8'hDA
`define RGT_GROUP_STRIDE 8'h03
`define RGT_BIT_SWI 14
`define RGT_BIT_FLT 10
`define RGT_BIT_EVT 0
`define RGT_BIT_HIB 0
`define RGT_MASK_CTRL 16'h441F
`define RGT_MASK_TIME 16'hFFC0
`define RGT_MASK_LP 16'h331F
`define RGT_MASK_EVT 16'h0001
`define RGT_RST_CTRL 16'h001B
`define RGT_RST_TIME 16'h0000
`define RGT_RST_LP 16'h001C
`define RGT_RST_ZERO 16'h0000
`define RGT_SLOT_NONE 4'h0
`define RGT_SLOT_LAST 4'hF
`define RGT_VOLT_HALF 5'h10
`define RGT_MV_BASE_LO 900
`define RGT_MV_STEP_LO 50
`define RGT_MV_BASE_HI 1800
`define RGT_MV_STEP_HI 100
`define RGT_MV_OFF 12'h000
`define RGT_RESP_OKAY 2'h0
`define RGT_RESP_SLVERR 2'h2
`endif

// [pkg/rgt_pkg.sv]
// rgt_pkg: types and helpers of the regulator-two register set.
// assumes rgt_regs.svh is on the include path.
`include "rgt_regs.svh"
package rgt_pkg;
    typedef enum logic [1:0] {
        RGT_ACT_IGNORE = 2'b00,
        RGT_ACT_REG_OFF = 2'b01,
        RGT_ACT_SYS_OFF = 2'b10,
        RGT_ACT_SYS_RSV = 2'b11
    } rgt_fault_type;
    typedef enum logic [1:0] {
        RGT_HIB_IMAGE = 2'b00,
        RGT_HIB_OFF = 2'b01,
        RGT_HIB_RSV_A = 2'b10,
        RGT_HIB_RSV_B = 2'b11
    } rgt_hib_type;
    typedef enum logic [1:0] {
        RGT_WR_IDLE = 2'b00,
        RGT_WR_ADDR = 2'b01,
        RGT_WR_DATA = 2'b10,
        RGT_WR_RESP = 2'b11
    } rgt_wr_type;
    typedef struct packed {
        logic enable;
        logic switch_mode;
        logic discharge;
        logic [4:0] voltage_code;
        logic [11:0] voltage_mv;
    } rgt_drive_type;
    typedef struct packed {
        logic start_never;
        logic start_on_active;
        logic [3:0] start_slot;
        logic stop_on_off;
        logic [3:0] stop_slot;
    } rgt_seq_type;
    // code to millivolts, two linear segments
    function automatic logic [11:0] rgt_code_mv(input logic [4:0] code);
        if (code < `RGT_VOLT_HALF) begin
            return 12'(`RGT_MV_BASE_LO + 32'(code[3:0]) * `RGT_MV_STEP_LO);
        end
        return 12'(`RGT_MV_BASE_HI + 32'(code[3:0]) * `RGT_MV_STEP_HI);
    endfunction
endpackage

// [src/rgt_sync.sv]
// rgt_sync: two-flop synchronisers for pin-level inputs.
// assumes inputs are asynchronous to aclk.
`timescale 1ns/1ps
module rgt_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_sync
);
    logic [3:0] stage_one;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_one <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            stage_one <= pin_in;
            pin_sync <= stage_one;
        end
    end
endmodule

// [src/rgt_regulator_two.sv]
// rgt_regulator_two: regulator-two control/status registers over AXI4-Lite,
// plus the drive, sequencing and fault decoding they steer.
// assumes same-clock sequencer and restore inputs; fault and low-power pins async.
`timescale 1ns/1ps
`include "rgt_regs.svh"
module rgt_regulator_two #(
    parameter logic [15:0] CTRL_DEFAULT = `RGT_RST_CTRL,
    parameter logic [15:0] TIME_DEFAULT = `RGT_RST_TIME
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`RGT_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`RGT_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sm_restore,
    input wire logic seq_enable,
    input wire logic [2:0] others_disabled,
    input wire logic fault_pin,
    input wire logic low_power_input_one,
    input wire logic low_power_input_two,
    input wire logic low_power_input_three,
    output rgt_pkg::rgt_drive_type drive,
    output rgt_pkg::rgt_seq_type seq,
    output logic shut_regulator,
    output logic shut_system,
    output logic sleep_active,
    output logic irq
);
    import rgt_pkg::*;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [15:0] ctrl;
    logic [15:0] timing;
    logic [15:0] low_power;
    logic [15:0] status;
    logic [15:0] mask;
    logic [15:0] hib_ctrl;
    rgt_wr_type wr_state;
    rgt_wr_type next_wr_state;
    logic [`RGT_ADDR_W-1:0] aw_hold;
    logic [31:0] w_hold;
    logic [3:0] strb_hold;
    logic wr_go;
    logic fault_seen;
    logic fault_off;

    function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] data,
                                                input logic [3:0] strb, input logic [15:0] keep);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res & keep;
    endfunction

    function automatic logic [`RGT_IDX_W-1:0] word_index(input logic [`RGT_ADDR_W-1:0] addr);
        return addr[`RGT_ADDR_W-1:2];
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] pins_sync;
    rgt_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({fault_pin, low_power_input_three, low_power_input_two, low_power_input_one}),
        .pin_sync(pins_sync)
    );

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    assign awready = (wr_state == RGT_WR_IDLE) || (wr_state == RGT_WR_DATA);
    assign wready = (wr_state == RGT_WR_IDLE) || (wr_state == RGT_WR_ADDR);
    assign bvalid = (wr_state == RGT_WR_RESP) && !wr_go;
    wire [`RGT_IDX_W-1:0] wr_idx = word_index(aw_hold);
    wire wr_ctrl = wr_go && (wr_idx == `RGT_IDX_CTRL);
    wire wr_time = wr_go && (wr_idx == `RGT_IDX_TIME);
    wire wr_lp = wr_go && (wr_idx == `RGT_IDX_LP);
    wire wr_stat = wr_go && (wr_idx == `RGT_IDX_STAT);
    wire wr_mask = wr_go && (wr_idx == `RGT_IDX_MASK);
    wire wr_hib = wr_go && (wr_idx == `RGT_IDX_HIB);
    wire wr_hit = wr_ctrl || wr_time || wr_lp || wr_stat || wr_mask || wr_hib;

    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            RGT_WR_IDLE: begin
                if (aw_take && w_take) begin
                    next_wr_state = RGT_WR_RESP;
                end else if (aw_take) begin
                    next_wr_state = RGT_WR_ADDR;
                end else if (w_take) begin
                    next_wr_state = RGT_WR_DATA;
                end
            end
            RGT_WR_ADDR: begin
                if (w_take) begin
                    next_wr_state = RGT_WR_RESP;
                end
            end
            RGT_WR_DATA: begin
                if (aw_take) begin
                    next_wr_state = RGT_WR_RESP;
                end
            end
            RGT_WR_RESP: begin
                if (bvalid && bready) begin
                    next_wr_state = RGT_WR_IDLE;
                end
            end
            default: next_wr_state = RGT_WR_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= RGT_WR_IDLE;
            aw_hold <= '0;
            w_hold <= 32'h0000_0000;
            strb_hold <= 4'h0;
            wr_go <= 1'b0;
            bresp <= `RGT_RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            wr_go <= (wr_state != RGT_WR_RESP) && (next_wr_state == RGT_WR_RESP);
            if (aw_take) begin
                aw_hold <= awaddr;
            end
            if (w_take) begin
                w_hold <= wdata;
                strb_hold <= wstrb;
            end
            if (wr_go) begin
                bresp <= wr_hit ? `RGT_RESP_OKAY : `RGT_RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------
    // registers; restore returns control, timing and low-power defaults
    // ----------------------------------------
    wire fault_rise = pins_sync[3] && !fault_seen;
    wire clr_evt = wr_stat && strb_hold[0] && w_hold[`RGT_BIT_EVT];

    always_ff @(posedge aclk) begin
        if (!aresetn || sm_restore) begin
            ctrl <= CTRL_DEFAULT;
            timing <= TIME_DEFAULT;
            low_power <= `RGT_RST_LP;
        end else begin
            if (wr_ctrl) begin
                ctrl <= merge_lanes(ctrl, w_hold, strb_hold, `RGT_MASK_CTRL);
            end
            if (wr_time) begin
                timing <= merge_lanes(timing, w_hold, strb_hold, `RGT_MASK_TIME);
            end
            if (wr_lp) begin
                low_power <= merge_lanes(low_power, w_hold, strb_hold, `RGT_MASK_LP);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= `RGT_RST_ZERO;
            mask <= `RGT_RST_ZERO;
            hib_ctrl <= `RGT_RST_ZERO;
            fault_seen <= 1'b0;
        end else begin
            fault_seen <= pins_sync[3];
            // a new fault beats a clear in the same cycle
            if (fault_rise) begin
                status[`RGT_BIT_EVT] <= 1'b1;
            end else if (clr_evt) begin
                status[`RGT_BIT_EVT] <= 1'b0;
            end
            if (wr_mask) begin
                mask <= merge_lanes(mask, w_hold, strb_hold, `RGT_MASK_EVT);
            end
            if (wr_hib) begin
                hib_ctrl <= merge_lanes(hib_ctrl, w_hold, strb_hold, `RGT_MASK_EVT);
            end
        end
    end

    assign irq = |(status & mask);

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    wire [`RGT_IDX_W-1:0] rd_idx = word_index(araddr);
    wire rd_ctrl = rd_idx == `RGT_IDX_CTRL;
    wire rd_time = rd_idx == `RGT_IDX_TIME;
    wire rd_lp = rd_idx == `RGT_IDX_LP;
    wire rd_stat = rd_idx == `RGT_IDX_STAT;
    wire rd_mask = rd_idx == `RGT_IDX_MASK;
    wire rd_hib = rd_idx == `RGT_IDX_HIB;
    // the next regulator's group starts one stride above this control index
    wire [`RGT_IDX_W-1:0] group_end = `RGT_IDX_CTRL + `RGT_GROUP_STRIDE;
    wire rd_group = (rd_idx >= `RGT_IDX_CTRL) && (rd_idx < group_end);
    wire rd_hit = rd_group || rd_stat || rd_mask || rd_hib;
    // unused bits stay zero through the write masks
    wire [15:0] rd_word = ({16{rd_ctrl}} & ctrl) | ({16{rd_time}} & timing)
                        | ({16{rd_lp}} & low_power) | ({16{rd_stat}} & status)
                        | ({16{rd_mask}} & mask) | ({16{rd_hib}} & hib_ctrl);
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RGT_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_word};
            rresp <= rd_hit ? `RGT_RESP_OKAY : `RGT_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // sleep selection and drive
    // ----------------------------------------
    wire [1:0] src_sel = low_power[9:8];
    wire [3:0] src_vec = {pins_sync[2:0], hib_ctrl[`RGT_BIT_HIB]};
    wire sleep_now = src_vec[src_sel];
    wire rgt_hib_type hib_mode = rgt_hib_type'(low_power[13:12]);
    wire use_image = sleep_now && (hib_mode == RGT_HIB_IMAGE);
    wire sleep_off = sleep_now && (hib_mode == RGT_HIB_OFF);
    wire rgt_fault_type action = rgt_fault_type'(timing[15:14]);
    wire next_enable = seq_enable && !fault_off && !sleep_off;
    wire [4:0] next_code = use_image ? low_power[4:0] : ctrl[4:0];
    wire next_switch = ctrl[`RGT_BIT_SWI];
    wire all_off = !next_enable && (&others_disabled);
    rgt_drive_type next_drive;
    rgt_seq_type next_seq;

    always_comb begin
        next_drive.enable = next_enable;
        next_drive.switch_mode = next_switch;
        next_drive.discharge = !next_enable && (!ctrl[`RGT_BIT_FLT] || all_off);
        next_drive.voltage_code = next_code;
        next_drive.voltage_mv = next_switch ? `RGT_MV_OFF : rgt_code_mv(next_code);
        next_seq.start_never = timing[13:10] == `RGT_SLOT_NONE;
        next_seq.start_on_active = timing[13:10] == `RGT_SLOT_LAST;
        next_seq.start_slot = timing[13:10];
        next_seq.stop_on_off = (timing[9:6] == `RGT_SLOT_NONE) || (timing[9:6] == `RGT_SLOT_LAST);
        next_seq.stop_slot = timing[9:6];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive <= '0;
            seq <= '0;
            sleep_active <= 1'b0;
            shut_regulator <= 1'b0;
            shut_system <= 1'b0;
            fault_off <= 1'b0;
        end else begin
            drive <= next_drive;
            seq <= next_seq;
            sleep_active <= sleep_now;
            shut_regulator <= fault_rise && (action == RGT_ACT_REG_OFF);
            shut_system <= fault_rise && timing[15];
            if (fault_rise && (action == RGT_ACT_REG_OFF)) begin
                fault_off <= 1'b1;
            end else if (!seq_enable) begin
                fault_off <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_fault_irq_set: assert property (fault_rise |=> status[`RGT_BIT_EVT])
        else $error("fault did not set status");
    chk_irq_unmasked: assert property (fault_rise && mask[`RGT_BIT_EVT] && !wr_mask |=> irq)
        else $error("unmasked fault gave no interrupt");
    chk_switch_volt: assert property (ctrl[`RGT_BIT_SWI] |=> drive.voltage_mv == `RGT_MV_OFF)
        else $error("switch mode still reports voltage");
    chk_float_discharge: assert property (!next_enable && !ctrl[`RGT_BIT_FLT] |=> drive.discharge)
        else $error("no discharge with float clear");
    chk_all_off: assert property (!next_enable && (&others_disabled) |=> drive.discharge)
        else $error("all regulators off without discharge");
    chk_volt_map: assert property (!next_switch && next_code == `RGT_VOLT_HALF
                                   |=> drive.voltage_mv == 12'(`RGT_MV_BASE_HI))
        else $error("upper segment base wrong");
    chk_restore_vals: assert property (sm_restore |=> ctrl == CTRL_DEFAULT && low_power == `RGT_RST_LP)
        else $error("restore left fields changed");
    chk_fault_reg: assert property (fault_rise && action == RGT_ACT_REG_OFF
                                    |=> shut_regulator ##1 !shut_regulator)
        else $error("regulator shutdown pulse wrong");
    chk_fault_ignore: assert property (fault_rise && action == RGT_ACT_IGNORE
                                       |=> !shut_regulator && !shut_system)
        else $error("ignored fault caused shutdown");
    chk_start_active: assert property (timing[13:10] == `RGT_SLOT_LAST |=> seq.start_on_active)
        else $error("start code 1111 not decoded");
    chk_stop_off: assert property (timing[9:6] == `RGT_SLOT_NONE |=> seq.stop_on_off)
        else $error("stop code 0000 not decoded");
    chk_sleep_off: assert property (sleep_now && hib_mode == RGT_HIB_OFF |=> !drive.enable)
        else $error("sleep disable kept output on");
    chk_image_code: assert property (use_image |=> drive.voltage_code == $past(low_power[4:0]))
        else $error("image code not applied");
    chk_rsv_normal: assert property (sleep_now && hib_mode[1] |=> drive.voltage_code == $past(ctrl[4:0]))
        else $error("reserved sleep code changed settings");
    chk_group_span: assert property (arvalid && arready && rd_idx == group_end
                                     |=> rresp == `RGT_RESP_SLVERR)
        else $error("next group index read as mapped");

    cov_write_ctrl: cover property (wr_ctrl ##1 bvalid && bready);
    cov_fault_reg: cover property (fault_rise && action == RGT_ACT_REG_OFF);
    cov_sleep_image: cover property (use_image && sleep_active);
    cov_fault_sys: cover property (fault_rise && timing[15]);
    cov_sleep_pin: cover property (src_sel != 2'b00 && $rose(sleep_now));
endmodule

// [sim/rgt_regulator_two_tb.sv]
// rgt_regulator_two_tb: self-checking bench for the regulator-two register set.
// assumes rgt_pkg is compiled first and rgt_regs.svh is on the include path.
`timescale 1ns/1ps
`include "rgt_regs.svh"
module rgt_regulator_two_tb;
    import rgt_pkg::*;
    localparam logic [9:0] A_CTRL = {`RGT_IDX_CTRL, 2'b00};
    localparam logic [9:0] A_TIME = {`RGT_IDX_TIME, 2'b00};
    localparam logic [9:0] A_LP = {`RGT_IDX_LP, 2'b00};
    localparam logic [9:0] A_STAT = {`RGT_IDX_STAT, 2'b00};
    localparam logic [9:0] A_MASK = {`RGT_IDX_MASK, 2'b00};
    localparam logic [9:0] A_HIB = {`RGT_IDX_HIB, 2'b00};
    localparam logic [1:0] OK = `RGT_RESP_OKAY;
    localparam logic [1:0] ERR = `RGT_RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [`RGT_ADDR_W-1:0] awaddr = '0;
    logic [`RGT_ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic sm_restore = 1'b0;
    logic seq_enable = 1'b0;
    logic [2:0] others_disabled = 3'h0;
    logic fault_pin = 1'b0;
    logic [2:0] lp_pins = 3'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    rgt_drive_type drive;
    rgt_seq_type seq;
    logic shut_regulator, shut_system, sleep_active, irq;
    int num_errors = 0;
    int check_count = 0;
    int n_reg = 0;
    int n_sys = 0;
    int mv;
    logic [4:0] code;
    logic [3:0] s, p;
    logic [33:0] exp_q[$];
    logic [1:0] exp_b[$];
    logic [4:0] bnd[4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
    logic [3:0] slots[4] = '{4'h0, 4'h1, 4'hE, 4'hF};

    rgt_regulator_two u_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .sm_restore, .seq_enable, .others_disabled, .fault_pin,
        .low_power_input_one(lp_pins[0]), .low_power_input_two(lp_pins[1]),
        .low_power_input_three(lp_pins[2]), .drive, .seq, .shut_regulator, .shut_system,
        .sleep_active, .irq
    );

    always #10 aclk = ~aclk;

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask

    // upper half carries random junk, which must be ignored
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad;
        bit dd;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'($urandom), d[15:0]};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        exp_b.push_back(er);
        ad = 0;
        dd = 0;
        do begin
            @(posedge aclk);
            if (awready === 1'b1 && !ad) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !dd) begin
                dd = 1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [1:0] er, input logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        exp_q.push_back({er, d});
        do begin
            @(posedge aclk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // ----------------------------------------
    // output watchers
    // ----------------------------------------
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (exp_q.size() == 0)
                chk({rresp, rdata}, 36'hF_FFFF_FFFF);
            else
                chk({rresp, rdata}, exp_q.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            if (exp_b.size() == 0)
                chk(bresp, 36'hF_FFFF_FFFF);
            else
                chk(bresp, exp_b.pop_front());
        end
        if (shut_regulator === 1'b1)
            n_reg++;
        if (shut_system === 1'b1)
            n_sys++;
    end

    initial begin
        repeat (30000) @(posedge aclk);
        num_errors++;
        wrap_up();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hCBAF));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CTRL, OK, 32'h001B);
        rd(A_TIME, OK, 32'h0000);
        rd(A_LP, OK, 32'h001C);
        rd(A_CTRL + 10'h00C, ERR, 32'h0);
        wr(A_CTRL + 10'h00C, 32'hFFFF, ERR);
        wr(A_CTRL, 32'hFFFF, OK);
        rd(A_CTRL, OK, 32'h441F);
        wr(A_TIME, 32'hFFFF, OK);
        rd(A_TIME, OK, 32'hFFC0);
        wr(A_LP, 32'hFFFF, OK);
        rd(A_LP, OK, 32'h331F);
        wr(A_MASK, 32'h1, OK);
        @(posedge aclk);
        sm_restore <= 1'b1;
        @(posedge aclk);
        sm_restore <= 1'b0;
        rd(A_CTRL, OK, 32'h001B);
        rd(A_TIME, OK, 32'h0000);
        rd(A_LP, OK, 32'h001C);
        rd(A_MASK, OK, 32'h1);
        // low lane only: upper control bits keep their value
        wstrb <= 4'h1;
        wr(A_CTRL, 32'hFFFF, OK);
        wstrb <= 4'hF;
        rd(A_CTRL, OK, 32'h001F);
        // voltage map: boundaries then random codes
        for (int i = 0; i < 12; i++) begin
            code = (i < 4) ? bnd[i] : 5'($urandom);
            wr(A_CTRL, {27'h0, code}, OK);
            tick(2);
            mv = (code < 5'h10) ? 900 + 50 * code : 1800 + 100 * (code - 16);
            chk(drive.voltage_mv, 36'(mv));
            chk(drive.voltage_code, code);
        end
        wr(A_CTRL, 32'h401B, OK);
        tick(2);
        chk(drive.switch_mode, 1'b1);
        chk(drive.voltage_mv, 12'h000);
        for (int k = 0; k < 4; k++) begin
            wr(A_CTRL, (k > 0) ? 32'h041B : 32'h001B, OK);
            @(posedge aclk);
            others_disabled <= (k == 2) ? 3'h7 : ((k == 3) ? 3'h3 : 3'h0);
            tick(2);
            chk(drive.discharge, 1'(k == 0 || k == 2));
        end
        for (int i = 0; i < 4; i++) begin
            s = slots[i];
            p = slots[3 - i];
            wr(A_TIME, {16'h0, 2'b00, s, p, 6'h0}, OK);
            tick(2);
            chk(seq, {s == 4'h0, s == 4'hF, s, p == 4'h0 || p == 4'hF, p});
        end
        // fault reactions, interrupt unmasked
        for (int a = 0; a < 4; a++) begin
            wr(A_TIME, {16'h0, 2'(a), 14'h0}, OK);
            n_reg = 0;
            n_sys = 0;
            @(posedge aclk);
            fault_pin <= 1'b1;
            tick(6);
            chk(irq, 1'b1);
            chk(32'(n_reg), 32'(a == 1));
            chk(32'(n_sys), 32'(a >= 2));
            @(posedge aclk);
            fault_pin <= 1'b0;
            rd(A_STAT, OK, 32'h1);
            wr(A_STAT, 32'h1, OK);
            tick(1);
            chk(irq, 1'b0);
        end
        // masked fault still latches status
        wr(A_MASK, 32'h0, OK);
        @(posedge aclk);
        fault_pin <= 1'b1;
        tick(6);
        chk(irq, 1'b0);
        @(posedge aclk);
        fault_pin <= 1'b0;
        rd(A_STAT, OK, 32'h1);
        wr(A_STAT, 32'h1, OK);
        wr(A_TIME, 32'h0400, OK);
        wr(A_CTRL, 32'h001B, OK);
        @(posedge aclk);
        seq_enable <= 1'b1;
        tick(2);
        chk(drive.enable, 1'b1);
        chk(drive.discharge, 1'b0);
        // sleep sources and behaviours; unselected pins must not trigger
        for (int m = 0; m < 3; m++) begin
            for (int t = 0; t < 4; t++) begin
                wr(A_LP, 32'((m << 12) | (t << 8) | 5), OK);
                if (t == 0)
                    wr(A_HIB, 32'h1, OK);
                @(posedge aclk);
                lp_pins <= (t == 0) ? 3'h0 : 3'(1 << (t - 1));
                tick(5);
                chk(sleep_active, 1'b1);
                chk(drive.voltage_code, (m == 0) ? 5'h05 : 5'h1B);
                chk(drive.enable, 1'(m != 1));
                if (t == 0)
                    wr(A_HIB, 32'h0, OK);
                @(posedge aclk);
                lp_pins <= (t == 0) ? 3'h7 : ~3'(1 << (t - 1));
                tick(5);
                chk(sleep_active, 1'b0);
                chk(drive.voltage_code, 5'h1B);
                chk(drive.enable, 1'b1);
                @(posedge aclk);
                lp_pins <= 3'h0;
            end
        end
        tick(4);
        wrap_up();
    end
endmodule
